// *** inc/fis_pkg.sv ***
// shared constants, types and states of the floating stack arithmetic unit
package fis_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // instruction decode: 0750xR, bits 4:3 pick the operation, 2:0 the register
    localparam logic [15:0] FIS_OPC_BASE  = 16'h7a00;
    localparam logic [15:0] FIS_OPC_MASK  = 16'hffe0;
    localparam int          FIS_OP_LSB    = 3;
    // operand stack offsets from the pointer, in bytes
    localparam logic [15:0] FIS_B_HI_OFS  = 16'h0000;
    localparam logic [15:0] FIS_B_LO_OFS  = 16'h0002;
    localparam logic [15:0] FIS_A_HI_OFS  = 16'h0004;
    localparam logic [15:0] FIS_A_LO_OFS  = 16'h0006;
    localparam logic [15:0] FIS_PTR_STEP  = 16'h0004;
    // trap vector 244 octal
    localparam logic [15:0] FIS_TRAP_VEC  = 16'h00a4;
    // excess-128 exponent, fraction 0.1fff with hidden bit
    localparam logic signed [10:0] FIS_EXP_BIAS = 11'sh080;
    localparam logic signed [10:0] FIS_EXP_MAX  = 11'sh0ff;
    localparam logic signed [10:0] FIS_EXP_MIN  = 11'sh001;
    localparam logic [4:0]  FIS_DIV_STEPS = 5'h1a;
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        FIS_FLOAT_ADD_OP      = 2'h0,
        FIS_FLOAT_SUBTRACT_OP = 2'h1,
        FIS_FLOAT_MULTIPLY_OP = 2'h2,
        FIS_FLOAT_DIVIDE_OP   = 2'h3
    } fis_op_t;
    typedef enum logic [4:0] {
        FIS_S_IDLE  = 5'h01,
        FIS_S_READ  = 5'h02,
        FIS_S_CALC  = 5'h04,
        FIS_S_DIV   = 5'h08,
        FIS_S_WRITE = 5'h10
    } fis_state_t;
    // condition code group of the processor_status_word
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } fis_cc_t;
    // memory request toward the processor bus
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fis_bus_t;
    // unpacked operand: sign, exponent, mantissa with hidden bit
    typedef struct packed {
        logic        s;
        logic [7:0]  e;
        logic [23:0] m;
    } fis_unp_t;
endpackage

// *** verilog/fis_unit.sv ***
// float_instruction_option unit: stack-based add, subtract, multiply, divide
`timescale 1ns/10ps
module fis_unit
    import fis_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    input  wire logic [15:0] ptr_val,
    input  wire logic        irq,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output fis_bus_t         mem,
    output logic             instr_accept,
    output logic             busy,
    output logic             reg_we,
    output logic [2:0]       reg_sel,
    output logic [15:0]      reg_wdata,
    output fis_cc_t          cc,
    output logic             cc_we,
    output logic             trap,
    output logic [15:0]      trap_vec,
    output logic             abort
);
    ////////////////////////////////////////////////////////////////////////////
    // split a two-word value into sign, exponent and mantissa
    function automatic fis_unp_t fis_unpack(input logic [15:0] hi, input logic [15:0] lo);
        fis_unp_t u;
        u.s = hi[15];
        u.e = hi[14:7];
        u.m = {hi[14:7] != 8'h00, hi[6:0], lo};
        return u;
    endfunction
    function automatic logic [4:0] fis_lead0(input logic [26:0] x);
        logic [4:0] n;
        n = 5'h1b;
        for (int i = 0; i < 27; i++) begin
            if (x[i]) begin
                n = 5'(26 - i);
            end
        end
        return n;
    endfunction

    fis_state_t    state_reg, state_next;
    fis_op_t       op_reg, op_next;
    logic [2:0]    sel_reg, sel_next;
    logic [15:0]   ptr_reg, ptr_next;
    logic [1:0]    idx_reg, idx_next;
    logic [15:0]   w_reg [0:3];
    logic [15:0]   w_next [0:3];
    logic [25:0]   rem_reg, rem_next, quo_reg, quo_next;
    logic [4:0]    cnt_reg, cnt_next;
    logic [31:0]   res_reg, res_next;
    fis_bus_t      bus_reg, bus_next;
    fis_cc_t       cc_reg, cc_next;
    logic          ccwe_reg, ccwe_next, trap_reg, trap_next;
    logic          abort_reg, abort_next, rwe_reg, rwe_next;
    fis_unp_t      ua, ub, big, sml;
    logic          swap, fin, cs, cz, ovf, unf, ge, b_zero;
    logic [26:0]   mb, ms, sum, sh;
    logic [4:0]    lz;
    logic [47:0]   prod;
    logic signed [10:0] ce;
    logic [23:0]   cm;

    ////////////////////////////////////////////////////////////////////////////
    // decode: the low five bits are free, the rest must match exactly
    assign instr_accept = (state_reg == FIS_S_IDLE) && instr_valid
                          && ((instr & FIS_OPC_MASK) == FIS_OPC_BASE);
    assign busy      = (state_reg != FIS_S_IDLE);
    assign mem       = bus_reg;
    assign reg_we    = rwe_reg;
    assign reg_sel   = sel_reg;
    assign reg_wdata = ptr_reg;
    assign cc        = cc_reg;
    assign cc_we     = ccwe_reg;
    assign trap      = trap_reg;
    assign trap_vec  = FIS_TRAP_VEC;
    assign abort     = abort_reg;

    // arithmetic on the captured words, A left and B right
    always_comb begin
        ua = fis_unpack(w_reg[2], w_reg[3]);
        ub = fis_unpack(w_reg[0], w_reg[1]);
        b_zero = (ub.e == 8'h00);
        ub.s = ub.s ^ (op_reg == FIS_FLOAT_SUBTRACT_OP);
        // order by magnitude so the difference never goes negative
        swap = (ua.e < ub.e) || ((ua.e == ub.e) && (ua.m < ub.m));
        big  = swap ? ub : ua;
        sml  = swap ? ua : ub;
        mb   = {1'b0, big.m, 2'b00};
        ms   = {1'b0, sml.m, 2'b00} >> (big.e - sml.e);
        sum  = (big.s == sml.s) ? mb + ms : mb - ms;
        lz   = fis_lead0(sum);
        sh   = sum << (lz - 5'h01);
        prod = {24'h00_0000, ua.m} * {24'h00_0000, ub.m};
        ge   = (rem_reg >= {2'b00, ub.m});
        cs   = ua.s ^ ub.s;
        cz   = 1'b0;
        cm   = 24'h00_0000;
        ce   = 11'sh000;
        case (op_reg)
            FIS_FLOAT_ADD_OP, FIS_FLOAT_SUBTRACT_OP: begin
                cs = big.s;
                cz = (sum == 27'h000_0000);
                cm = sum[26] ? sum[26:3] : sh[25:2];
                ce = sum[26] ? $signed({3'b000, big.e}) + 11'sh001
                             : $signed({3'b000, big.e}) - $signed({6'h00, lz}) + 11'sh001;
            end
            FIS_FLOAT_MULTIPLY_OP: begin
                cz = (ua.e == 8'h00) || b_zero;
                cm = prod[47] ? prod[47:24] : prod[46:23];
                ce = $signed({3'b000, ua.e}) + $signed({3'b000, ub.e}) - FIS_EXP_BIAS
                     - (prod[47] ? 11'sh000 : 11'sh001);
            end
            default: begin
                cz = (ua.e == 8'h00);
                cm = quo_reg[25] ? quo_reg[25:2] : quo_reg[24:1];
                ce = $signed({3'b000, ua.e}) - $signed({3'b000, ub.e}) + FIS_EXP_BIAS
                     + (quo_reg[25] ? 11'sh001 : 11'sh000);
            end
        endcase
        ovf = !cz && (ce > FIS_EXP_MAX);
        unf = !cz && (ce < FIS_EXP_MIN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: read four words, compute, write two words, step pointer
    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        sel_next   = sel_reg;
        ptr_next   = ptr_reg;
        idx_next   = idx_reg;
        w_next     = w_reg;
        rem_next   = rem_reg;
        quo_next   = quo_reg;
        cnt_next   = cnt_reg;
        res_next   = res_reg;
        bus_next   = bus_reg;
        cc_next    = cc_reg;
        ccwe_next  = 1'b0;
        trap_next  = 1'b0;
        abort_next = 1'b0;
        rwe_next   = 1'b0;
        fin        = 1'b0;
        case (state_reg)
            FIS_S_IDLE: begin
                if (instr_accept) begin
                    op_next    = fis_op_t'(instr[FIS_OP_LSB +: 2]);
                    sel_next   = instr[2:0];
                    ptr_next   = ptr_val;
                    idx_next   = 2'h0;
                    bus_next   = '{req: 1'b1, we: 1'b0, addr: ptr_val + FIS_B_HI_OFS, wdata: 16'h0000};
                    state_next = FIS_S_READ;
                end
            end
            FIS_S_READ: begin
                if (mem_ack) begin
                    w_next[idx_reg] = mem_rdata;
                    idx_next = idx_reg + 2'h1;
                    // word order B hi, B lo, A hi, A lo
                    bus_next.addr = ptr_reg + {13'h0000, idx_reg + 2'h1, 1'b0};
                    if (idx_reg == 2'h3) begin
                        bus_next.req = 1'b0;
                        state_next   = FIS_S_CALC;
                    end
                end
            end
            FIS_S_CALC: begin
                if (op_reg != FIS_FLOAT_DIVIDE_OP) begin
                    fin = 1'b1;
                end else if (b_zero) begin
                    // divide by zero: nothing written, pointer kept
                    trap_next  = 1'b1;
                    ccwe_next  = 1'b1;
                    cc_next    = '{n: 1'b1, z: 1'b0, v: 1'b1, c: 1'b1};
                    state_next = FIS_S_IDLE;
                end else begin
                    rem_next   = {2'b00, ua.m};
                    quo_next   = 26'h000_0000;
                    cnt_next   = FIS_DIV_STEPS;
                    state_next = FIS_S_DIV;
                end
            end
            FIS_S_DIV: begin
                // restoring divide, one quotient bit per clock
                if (cnt_reg != 5'h00) begin
                    quo_next = {quo_reg[24:0], ge};
                    rem_next = (ge ? rem_reg - {2'b00, ub.m} : rem_reg) << 1;
                    cnt_next = cnt_reg - 5'h01;
                end else begin
                    fin = 1'b1;
                end
            end
            FIS_S_WRITE: begin
                if (mem_ack && idx_reg == 2'h0) begin
                    idx_next = 2'h1;
                    bus_next.addr  = ptr_reg + FIS_A_LO_OFS;
                    bus_next.wdata = res_reg[15:0];
                end else if (mem_ack) begin
                    bus_next   = '{req: 1'b0, we: 1'b0, addr: bus_reg.addr, wdata: bus_reg.wdata};
                    ptr_next   = ptr_reg + FIS_PTR_STEP;
                    rwe_next   = 1'b1;
                    ccwe_next  = 1'b1;
                    cc_next    = '{n: res_reg[31], z: res_reg == 32'h0000_0000, v: 1'b0, c: 1'b0};
                    state_next = FIS_S_IDLE;
                end
            end
            default: begin
                state_next = FIS_S_IDLE;
            end
        endcase
        if (fin && (ovf || unf)) begin
            trap_next  = 1'b1;
            ccwe_next  = 1'b1;
            cc_next    = '{n: unf, z: 1'b0, v: 1'b1, c: 1'b0};
            state_next = FIS_S_IDLE;
        end else if (fin) begin
            res_next   = cz ? 32'h0000_0000 : {cs, ce[7:0], cm[22:0]};
            idx_next   = 2'h0;
            bus_next   = '{req: 1'b1, we: 1'b1, addr: ptr_reg + FIS_A_HI_OFS,
                           wdata: cz ? 16'h0000 : {cs, ce[7:0], cm[22:16]}};
            state_next = FIS_S_WRITE;
        end
        // once writing starts the instruction is near completion and runs out
        if (irq && (state_reg == FIS_S_READ || state_reg == FIS_S_CALC || state_reg == FIS_S_DIV)) begin
            bus_next   = '{req: 1'b0, we: 1'b0, addr: bus_reg.addr, wdata: bus_reg.wdata};
            trap_next  = 1'b0;
            ccwe_next  = 1'b0;
            cc_next    = cc_reg;
            abort_next = 1'b1;
            state_next = FIS_S_IDLE;
        end
    end

    // every register of the unit: state, operands, divider, result, bus and output flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= FIS_S_IDLE;
            op_reg    <= FIS_FLOAT_ADD_OP;
            sel_reg   <= 3'h0;
            ptr_reg   <= 16'h0000;
            idx_reg   <= 2'h0;
            w_reg     <= '{default: 16'h0000};
            rem_reg   <= 26'h000_0000;
            quo_reg   <= 26'h000_0000;
            cnt_reg   <= 5'h00;
            res_reg   <= 32'h0000_0000;
            bus_reg   <= '0;
            cc_reg    <= '0;
            ccwe_reg  <= 1'b0;
            trap_reg  <= 1'b0;
            abort_reg <= 1'b0;
            rwe_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            sel_reg   <= sel_next;
            ptr_reg   <= ptr_next;
            idx_reg   <= idx_next;
            w_reg     <= w_next;
            rem_reg   <= rem_next;
            quo_reg   <= quo_next;
            cnt_reg   <= cnt_next;
            res_reg   <= res_next;
            bus_reg   <= bus_next;
            cc_reg    <= cc_next;
            ccwe_reg  <= ccwe_next;
            trap_reg  <= trap_next;
            abort_reg <= abort_next;
            rwe_reg   <= rwe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_START_READ: assert property (instr_accept |=> mem.req && !mem.we && mem.addr == $past(ptr_val))
        else $error("first read not at pointer");
    AST_READ_A_LO: assert property (state_reg == FIS_S_READ && idx_reg == 2'h3 |-> mem.addr == ptr_reg + 16'h0006)
        else $error("A low word read at wrong address");
    AST_WRITE_ADDR: assert property (mem.req && mem.we |-> mem.addr == ptr_reg + 16'h0004 || mem.addr == ptr_reg + 16'h0006)
        else $error("result written outside A slot");
    AST_PTR_STEP: assert property (reg_we |-> reg_wdata == $past(ptr_reg) + 16'h0004 && $past(mem_ack))
        else $error("pointer not advanced by four");
    AST_TRAP_CC: assert property (trap |-> cc_we && cc.v && !cc.z && !reg_we && trap_vec == 16'h00a4)
        else $error("trap condition codes wrong");
    AST_DIV_ZERO: assert property (state_reg == FIS_S_CALC && op_reg == FIS_FLOAT_DIVIDE_OP && b_zero && !irq
                                   |=> trap && cc.n && cc.c && !mem.req)
        else $error("divide by zero not trapped cleanly");
    AST_DONE_CC: assert property (reg_we |-> cc_we && !cc.v && !cc.c && !trap && cc.z == (res_reg == 32'h0000_0000))
        else $error("completion condition codes wrong");
    AST_ABORT: assert property (irq && (state_reg == FIS_S_READ || state_reg == FIS_S_CALC
                                        || state_reg == FIS_S_DIV)
                                |=> abort && !mem.req && !busy && !trap && !cc_we && !reg_we)
        else $error("interrupt did not abort");
endmodule

// *** testbench/fis_mem_model.sv ***
// behavioural memory that holds the operand stack for the floating unit
`timescale 1ns/10ps
module fis_mem_model
    import fis_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire fis_bus_t   mem,
    input  wire logic [1:0] lat,
    output logic [15:0]     mem_rdata,
    output logic            mem_ack,
    output int              wr_count
);
    logic [15:0] words [0:255];
    logic [1:0]  wait_reg;
    ////////////////////////////////////////////////////////////////////////////
    // one ack pulse per request after lat idle cycles; the data line toggles
    // when idle so a design that samples it late never sees a stale word;
    // plain always because the bench preloads the words array directly
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack   <= 1'b0;
            wait_reg  <= 2'h0;
            mem_rdata <= 16'h5a5a;
            wr_count  <= 0;
        end else if (mem.req && !mem_ack && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else if (mem.req && !mem_ack) begin
            mem_ack <= 1'b1;
            if (mem.we) begin
                words[mem.addr[8:1]] <= mem.wdata;
                wr_count             <= wr_count + 1;
            end else begin
                mem_rdata <= words[mem.addr[8:1]];
            end
        end else begin
            mem_ack   <= 1'b0;
            wait_reg  <= lat;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** testbench/tb_fis_unit.sv ***
// self-checking bench for the floating stack arithmetic unit
`timescale 1ns/10ps
module tb_fis_unit;
    import fis_pkg::*;
    logic        clk, rstn, instr_valid, irq, mem_ack;
    logic        instr_accept, busy, reg_we, cc_we, trap, abort;
    logic [15:0] instr, ptr_val, mem_rdata, reg_wdata, trap_vec;
    logic [2:0]  reg_sel;
    logic [1:0]  lat;
    fis_bus_t    mem;
    fis_cc_t     cc;
    int          wr_count;
    int          err_count = 0;
    int          checks = 0;
    int          seed = 39137;
    real         ar, br, rr;
    fis_op_t     op;

    fis_unit fis_unit_i (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .ptr_val(ptr_val), .irq(irq), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem(mem),
        .instr_accept(instr_accept), .busy(busy), .reg_we(reg_we), .reg_sel(reg_sel),
        .reg_wdata(reg_wdata), .cc(cc), .cc_we(cc_we), .trap(trap), .trap_vec(trap_vec),
        .abort(abort));
    fis_mem_model fis_mem_model_i (.clk(clk), .rstn(rstn), .mem(mem), .lat(lat),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wr_count(wr_count));
    ////////////////////////////////////////////////////////////////////////////
    // real to stored format: excess-128 with 0.1f fraction, so exponent is E-894
    function automatic logic [31:0] fis_of(input real r);
        logic [63:0] d;
        d = $realtobits(r);
        if (r == 0.0) return 32'h0000_0000;
        return {d[63], 8'(d[62:52] - 11'h37e), d[51:29]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // one instruction: preload the stack, issue, wait for the answer, compare;
    // irq_at >= 0 raises the interrupt that many cycles after acceptance
    task automatic do_op(input fis_op_t o, input logic [2:0] r, input logic [15:0] ptr,
                         input logic [31:0] a, input logic [31:0] b, input logic [31:0] res,
                         input fis_cc_t exp_cc, input logic exp_trap, input int irq_at);
        logic [7:0] ix;
        int         wc;
        int         n;
        ix = ptr[8:1];
        @(posedge clk);
        #1;
        wc = wr_count;
        fis_mem_model_i.words[ix] = b[31:16];
        fis_mem_model_i.words[ix + 8'h01] = b[15:0];
        fis_mem_model_i.words[ix + 8'h02] = a[31:16];
        fis_mem_model_i.words[ix + 8'h03] = a[15:0];
        lat = 2'($random(seed));
        instr = FIS_OPC_BASE | {11'h000, o, r};
        ptr_val = ptr;
        instr_valid = 1'b1;
        #1;
        check("accept", instr_accept, 1);
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        ptr_val = 16'($random(seed));
        n = 0;
        while (!(reg_we | trap | abort) && n < 2000) begin
            irq = (irq_at >= 0 && n >= irq_at);
            @(posedge clk);
            #1;
            n++;
        end
        irq = 1'b0;
        check("answered", n < 2000, 1);
        if (irq_at >= 0) begin
            check("abort", {abort, trap, cc_we, reg_we}, 4'h8);
        end else if (exp_trap) begin
            check("trap", {abort, trap, cc_we, reg_we}, 4'h6);
            check("trap_cc", cc, exp_cc);
            check("trap_vec", trap_vec, FIS_TRAP_VEC);
        end else begin
            check("done", {abort, trap, cc_we, reg_we}, 4'h3);
            check("reg_sel", reg_sel, r);
            check("reg_wdata", reg_wdata, ptr + FIS_PTR_STEP);
            check("cc", cc, exp_cc);
            wc += 2;
            a = res;
        end
        check("a_words", {fis_mem_model_i.words[ix + 8'h02], fis_mem_model_i.words[ix + 8'h03]}, a);
        check("b_words", {fis_mem_model_i.words[ix], fis_mem_model_i.words[ix + 8'h01]}, b);
        check("writes", wr_count, wc);
        check("busy", busy, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // limit is far above the few thousand cycles the sequence needs
    initial begin
        repeat (50000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end

    initial begin
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        ptr_val = 16'h0000;
        irq = 1'b0;
        lat = 2'h0;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        // foreign opcodes next to the group must never be taken
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            #1;
            instr = (k == 0) ? 16'h7a20 : (k == 1) ? 16'h79ff : 16'hfa00;
            instr_valid = 1'b1;
            #1;
            check("foreign", instr_accept, 0);
            @(posedge clk);
            #1;
            instr_valid = 1'b0;
            check("idle", busy, 0);
        end
        // traps: zero divisor, overflow, underflow, then an interrupted add
        do_op(FIS_FLOAT_DIVIDE_OP, 3'h2, 16'h0040, fis_of(3.0), 32'h0000_0000, 0, 4'hb, 1, -1);
        do_op(FIS_FLOAT_MULTIPLY_OP, 3'h5, 16'h0080, 32'h7f80_0000, 32'h7f80_0000, 0, 4'h2, 1, -1);
        do_op(FIS_FLOAT_MULTIPLY_OP, 3'h6, 16'h00c0, 32'h0080_0000, 32'h0080_0000, 0, 4'ha, 1, -1);
        do_op(FIS_FLOAT_ADD_OP, 3'h1, 16'h0100, fis_of(5.0), fis_of(2.0), 0, 4'h0, 0, 1);
        // random exact-valued operands: small integers against powers of two
        for (int i = 0; i < 60; i++) begin
            ar = real'($random(seed) % 17);
            br = (($random(seed) & 1) ? -1.0 : 1.0) * (2.0 ** (($random(seed) & 3) - 1));
            op = fis_op_t'(2'($random(seed)));
            case (op)
                FIS_FLOAT_ADD_OP:      rr = ar + br;
                FIS_FLOAT_SUBTRACT_OP: rr = ar - br;
                FIS_FLOAT_MULTIPLY_OP: rr = ar * br;
                default:               rr = ar / br;
            endcase
            do_op(op, 3'($random(seed)), 16'($random(seed)) & 16'h01f0, fis_of(ar), fis_of(br),
                  fis_of(rr), {rr < 0.0, rr == 0.0, 2'b00}, 0, -1);
        end
        tally_and_finish;
    end
endmodule
